// *** imp_ahb_slave.sv ***
// AHB-Lite slave front end: decodes the address phase and presents one
// write strobe and one read select in the data phase.
// Assumes single word transfers; never inserts wait states, always OKAY.
`include "imp_regs.svh"

module imp_ahb_slave (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave port
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output wire logic                 hreadyout,
  output wire logic                 hresp,
  // Register side
  output imp_pkg::imp_wr_t          reg_wr,
  output imp_pkg::imp_reg_sel_t     reg_rd_sel
);
  import imp_pkg::*;

  logic         ph_valid;
  logic         ph_write;
  imp_reg_sel_t ph_sel;
  imp_reg_sel_t next_sel;
  logic         take;

  // Only NONSEQ/SEQ with the bus ready start a transfer
  assign take = hsel && hready && htrans[1];

  // Address decode; misaligned or sub-word accesses fall to no register
  always_comb begin
    next_sel = IMP_R_NONE;
    if (haddr[1:0] == 2'b00 && hsize == 3'h2) begin
      case (haddr)
        `IMP_SRC_ADDR:   next_sel = IMP_R_SRC;
        `IMP_CLASS_ADDR: next_sel = IMP_R_CLASS;
        `IMP_MASK_ADDR:  next_sel = IMP_R_MASK;
        `IMP_ORDER_ADDR: next_sel = IMP_R_ORDER;
        `IMP_PEND_ADDR:  next_sel = IMP_R_PEND;
        `IMP_INDEX_ADDR: next_sel = IMP_R_INDEX;
        default:         next_sel = IMP_R_NONE;
      endcase
    end
  end

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_sel   <= IMP_R_NONE;
    end else if (hready) begin
      ph_valid <= take;
      ph_write <= hwrite;
      ph_sel   <= next_sel;
    end
  end

  // Zero wait states keep the interrupt path free of bus stalls
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign reg_wr.valid     = ph_valid && ph_write;
  assign reg_wr.sel       = ph_sel;
  assign reg_wr.data      = hwdata;
  assign reg_rd_sel       = (ph_valid && !ph_write) ? ph_sel : IMP_R_NONE;

endmodule : imp_ahb_slave

// *** imp_arb_group.sv ***
// One six-input arbiter group with a 2-bit order select and rotation.
// Four-input groups tie inputs 0 and 5 low and use inputs 1..4.
module imp_arb_group (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Requests and configuration
  input  wire logic [5:0] req,
  input  wire logic [1:0] order_sel,
  input  wire logic       rotate,
  input  wire logic       advance,
  // Grant
  output logic            grant_any,
  output logic [2:0]      grant_idx
);
  logic [1:0] offset;
  logic [1:0] start;
  logic [1:0] slot;

  assign start = order_sel + offset;

  // Input 0 first, inputs 1..4 from the start slot, input 5 last
  always_comb begin
    grant_any = 1'b0;
    grant_idx = 3'h0;
    slot      = 2'b00;
    if (req[0]) begin
      grant_any = 1'b1;
    end else begin
      for (int k = 3; k >= 0; k--) begin
        slot = start + 2'(k);
        if (req[{1'b0, slot} + 3'h1]) begin
          grant_any = 1'b1;
          grant_idx = {1'b0, slot} + 3'h1;
        end
      end
      if (!grant_any && req[5]) begin
        grant_any = 1'b1;
        grant_idx = 3'h5;
      end
    end
  end

  // The served middle input drops to last of the rotating slots
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      offset <= 2'b00;
    end else if (!rotate) begin
      offset <= 2'b00;
    end else if (advance && grant_idx != 3'h0 && grant_idx != 3'h5) begin
      offset <= grant_idx[1:0] - order_sel;
    end
  end

  input_zero_a : assert property (@(posedge hclk) disable iff (!hresetn)
    req[0] |-> grant_any && grant_idx == 3'h0)
    else $error("input 0 did not win");
  input_five_a : assert property (@(posedge hclk) disable iff (!hresetn)
    grant_idx == 3'h5 |-> req[4:0] == 5'h00)
    else $error("input 5 won over another request");
  rotate_step_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (rotate && advance && grant_idx == 3'h2) ##1 rotate |-> start == 2'b10)
    else $error("rotation did not move past the served input");

endmodule : imp_arb_group

// *** imp_core_model.sv ***
// Far-side model: the processor core's two interrupt inputs.
// Assumes both request levels are synchronous to hclk; an entry is a rise.
module imp_core_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Requests from the stage
  input  wire logic       normal_irq_req,
  input  wire logic       fast_interrupt_request,
  // Entry counts seen by the core
  output logic      [7:0] irq_entries,
  output logic      [7:0] fast_entries
);
  timeunit 1ns;
  timeprecision 100ps;
  logic irq_q;
  logic fast_q;

  // A held level is one entry only; the core re-enters only after a drop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q        <= 1'b0;
      fast_q       <= 1'b0;
      irq_entries  <= 8'h00;
      fast_entries <= 8'h00;
    end else begin
      irq_q  <= normal_irq_req;
      fast_q <= fast_interrupt_request;
      if (normal_irq_req && !irq_q) irq_entries <= irq_entries + 8'h01;
      if (fast_interrupt_request && !fast_q) fast_entries <= fast_entries + 8'h01;
    end
  end
endmodule : imp_core_model

// *** imp_irq_stage.sv ***
// Interrupt mask, priority arbitration and one-hot pending stage.
// Assumes source requests are same-clock levels and software on AHB-Lite.
`include "imp_regs.svh"

module imp_irq_stage (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave port
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output wire logic        hreadyout,
  output wire logic        hresp,
  output logic [31:0]      hrdata,
  // Interrupt sources, one level per source
  input  wire logic [31:0] src_req,
  // Requests towards the processor core
  output logic             normal_irq_req,
  output logic             fast_interrupt_request
);
  import imp_pkg::*;

  imp_wr_t      reg_wr;
  imp_reg_sel_t reg_rd_sel;

  logic [31:0]  source_pending_flags;
  logic [31:0]  interrupt_class_select;
  logic [31:0]  interrupt_mask_reg;
  logic [31:0]  arbiter_order_control;
  logic [31:0]  irq_pending_onehot;
  logic [4:0]   pending_index_reg;

  logic [31:0]  eligible;
  logic [5:0]   leaf_any;
  logic [5:0][2:0] leaf_idx;
  logic         top_any;
  logic [2:0]   top_idx;
  logic [4:0]   win_src;
  logic [31:0]  win_onehot;
  logic         load;
  logic [31:0]  next_pending;
  logic [4:0]   next_index;
  logic         wr_src;
  logic         wr_pend;

  // Bus front end
  imp_ahb_slave u_bus (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hready     (hready),
    .hwdata     (hwdata),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .reg_wr     (reg_wr),
    .reg_rd_sel (reg_rd_sel)
  );

  assign wr_src  = reg_wr.valid && reg_wr.sel == IMP_R_SRC;
  assign wr_pend = reg_wr.valid && reg_wr.sel == IMP_R_PEND;

  // Source flags: a request in the clearing cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_pending_flags <= `IMP_SRC_RST;
    end else if (wr_src) begin
      source_pending_flags <= (source_pending_flags & ~reg_wr.data) | src_req;
    end else begin
      source_pending_flags <= source_pending_flags | src_req;
    end
  end

  // Class select: only one fast source is expected, not enforced here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_class_select <= `IMP_CLASS_RST;
    end else if (reg_wr.valid && reg_wr.sel == IMP_R_CLASS) begin
      interrupt_class_select <= reg_wr.data;
    end
  end

  // Mask register, all sources masked out of reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_mask_reg <= `IMP_MASK_RST;
    end else if (reg_wr.valid && reg_wr.sel == IMP_R_MASK) begin
      interrupt_mask_reg <= reg_wr.data;
    end
  end

  // Order control; unused upper bits are not stored and read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arbiter_order_control <= `IMP_ORDER_RST;
    end else if (reg_wr.valid && reg_wr.sel == IMP_R_ORDER) begin
      arbiter_order_control <= reg_wr.data & `IMP_ORDER_USED;
    end
  end

  // Only unmasked normal-class waiting sources reach the arbiters
  assign eligible = source_pending_flags & ~interrupt_mask_reg & ~interrupt_class_select;

  // Leaf groups: 0 and 5 take four sources on inputs 1..4, others six
  for (genvar g = 0; g < 6; g++) begin : gen_leaf
    localparam int BASE = (g == 0) ? 0 : 4 + 6 * (g - 1);
    logic [5:0] leaf_req;
    if (g == 0 || g == 5) begin : gen_four
      assign leaf_req = {1'b0, eligible[BASE+3:BASE], 1'b0};
    end else begin : gen_six
      assign leaf_req = eligible[BASE+5:BASE];
    end
    imp_arb_group u_arb (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .req       (leaf_req),
      .order_sel (arbiter_order_control[`IMP_SEL_LSB + 2*g +: 2]),
      .rotate    (arbiter_order_control[`IMP_ROT_LSB + g]),
      .advance   (load && top_idx == 3'(g)),
      .grant_any (leaf_any[g]),
      .grant_idx (leaf_idx[g])
    );
  end

  // Final group 6 picks among the six leaf winners
  imp_arb_group u_arb_top (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .req       (leaf_any),
    .order_sel (arbiter_order_control[`IMP_SEL_LSB + 12 +: 2]),
    .rotate    (arbiter_order_control[`IMP_ROT_LSB + 6]),
    .advance   (load),
    .grant_any (top_any),
    .grant_idx (top_idx)
  );

  // Winning source number and its one-hot image
  always_comb begin
    win_src    = imp_src_index(top_idx, leaf_idx[top_idx]);
    win_onehot = 32'h00000001 << win_src;
  end

  // A new winner is latched only while the pending register is empty
  assign load = top_any && irq_pending_onehot == 32'h00000000;

  // Next pending value: write-one clear, then the load wins if both occur
  always_comb begin
    next_pending = irq_pending_onehot;
    if (wr_pend) begin
      next_pending = next_pending & ~reg_wr.data;
    end
    if (load) begin
      next_pending = win_onehot;
    end
    next_index = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (next_pending[i]) begin
        next_index = 5'(i);
      end
    end
  end

  // One-hot pending register and its index
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pending_onehot <= `IMP_PEND_RST;
      pending_index_reg  <= `IMP_INDEX_RST;
    end else begin
      irq_pending_onehot <= next_pending;
      pending_index_reg  <= next_index;
    end
  end

  // Normal request follows the pending register directly
  assign normal_irq_req = |irq_pending_onehot;

  // Fast request is registered; it bypasses arbitration entirely
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_interrupt_request <= 1'b0;
    end else begin
      fast_interrupt_request <= |(source_pending_flags & ~interrupt_mask_reg
                                  & interrupt_class_select);
    end
  end

  // Read data for the data phase; unmapped addresses read zero
  always_comb begin
    case (reg_rd_sel)
      IMP_R_SRC:   hrdata = source_pending_flags;
      IMP_R_CLASS: hrdata = interrupt_class_select;
      IMP_R_MASK:  hrdata = interrupt_mask_reg;
      IMP_R_ORDER: hrdata = arbiter_order_control;
      IMP_R_PEND:  hrdata = irq_pending_onehot;
      IMP_R_INDEX: hrdata = {27'h0000000, pending_index_reg};
      default:     hrdata = 32'h00000000;
    endcase
  end

  // Checks on the pending path
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  mask_reset_a : assert property ($past(hresetn) == 1'b0 |->
    interrupt_mask_reg == `IMP_MASK_RST)
    else $error("mask register not all ones after reset");
  order_reset_a : assert property ($past(hresetn) == 1'b0 |->
    arbiter_order_control == `IMP_ORDER_RST)
    else $error("order control not 0x7f after reset");
  pend_reset_a : assert property ($past(hresetn) == 1'b0 |->
    irq_pending_onehot == `IMP_PEND_RST && !normal_irq_req)
    else $error("pending register not clear after reset");
  pend_onehot_a : assert property ($onehot0(irq_pending_onehot))
    else $error("more than one pending bit set");
  load_irq_a : assert property (load |=> normal_irq_req
    && irq_pending_onehot == $past(win_onehot))
    else $error("winner not latched or request not raised");
  masked_out_a : assert property (load |->
    (win_onehot & interrupt_mask_reg) == 32'h00000000)
    else $error("masked source reached the pending register");
  fast_out_a : assert property (load |->
    (win_onehot & interrupt_class_select) == 32'h00000000)
    else $error("fast class source reached the pending register");
  flag_set_a : assert property ((src_req != 32'h00000000) |=>
    ($past(src_req) & ~source_pending_flags) == 32'h00000000)
    else $error("source request lost from pending flags");
  pend_clear_a : assert property (wr_pend && !load |=>
    irq_pending_onehot == ($past(irq_pending_onehot) & ~$past(reg_wr.data)))
    else $error("pending write did not clear exactly the ones");
  flag_clear_a : assert property (wr_src && src_req == 32'h00000000 |=>
    source_pending_flags == ($past(source_pending_flags) & ~$past(reg_wr.data)))
    else $error("source flag write did not clear exactly the ones");
  index_match_a : assert property (normal_irq_req |->
    irq_pending_onehot[pending_index_reg])
    else $error("index register does not name the pending bit");

  // Index follows the pending register back to zero once it empties
  index_reset_a : assert property ($past(hresetn) == 1'b0 |->
    pending_index_reg == `IMP_INDEX_RST)
    else $error("index register not zero after reset");
  index_idle_a : assert property (!normal_irq_req |->
    pending_index_reg == 5'h00)
    else $error("index register not cleared with the pending register");

  // Flags and class bits start clear
  flag_reset_a : assert property ($past(hresetn) == 1'b0 |->
    source_pending_flags == `IMP_SRC_RST && interrupt_class_select == `IMP_CLASS_RST)
    else $error("source flags or class bits not clear after reset");

  // The bus side never stalls and never reports an error
  bus_ready_a : assert property (hreadyout && !hresp)
    else $error("bus stalled or returned an error");

  // Register writes land on the edge that ends their data phase
  mask_write_a : assert property (reg_wr.valid && reg_wr.sel == IMP_R_MASK |=>
    interrupt_mask_reg == $past(reg_wr.data))
    else $error("mask write did not land");
  mask_hold_a : assert property (!(reg_wr.valid && reg_wr.sel == IMP_R_MASK) |=>
    $stable(interrupt_mask_reg))
    else $error("mask register changed without a write");
  class_write_a : assert property (reg_wr.valid && reg_wr.sel == IMP_R_CLASS |=>
    interrupt_class_select == $past(reg_wr.data))
    else $error("class write did not land");
  order_write_a : assert property (reg_wr.valid && reg_wr.sel == IMP_R_ORDER |=>
    arbiter_order_control == ($past(reg_wr.data) & `IMP_ORDER_USED))
    else $error("order control write did not land");
  order_hold_a : assert property (!(reg_wr.valid && reg_wr.sel == IMP_R_ORDER) |=>
    $stable(arbiter_order_control))
    else $error("order control changed without a write");

  // A set pending bit stands until software clears it
  pend_hold_a : assert property (!wr_pend && !load |=>
    irq_pending_onehot == $past(irq_pending_onehot))
    else $error("pending register changed on its own");
  // Only a waiting source can be latched as the winner
  pend_flag_a : assert property (load |->
    (win_onehot & source_pending_flags) != 32'h00000000)
    else $error("winner has no source flag set");
  // Fast request is the registered OR of unmasked fast-class flags
  fast_level_a : assert property (fast_interrupt_request ==
    $past(|(source_pending_flags & ~interrupt_mask_reg & interrupt_class_select)))
    else $error("fast request does not follow the fast-class flags");
  // All codes zero and rotation settled: lowest eligible source wins
  winner_first_a : assert property (load && arbiter_order_control == 32'h00000000
    && $past(arbiter_order_control) == 32'h00000000 |->
    win_onehot == (eligible & (~eligible + 32'h00000001)))
    else $error("default order did not pick the lowest source");

  rot_seen_c  : cover property (load && arbiter_order_control[6]);
  load_seen_c : cover property (load ##1 wr_pend ##1 !normal_irq_req);
  fast_seen_c : cover property (fast_interrupt_request && !normal_irq_req);
  set_clear_c : cover property (wr_src && (src_req & reg_wr.data) != 32'h00000000);
  two_wins_c  : cover property (load ##[1:20] load);

endmodule : imp_irq_stage

// *** imp_pkg.sv ***
// Types shared by the interrupt mask / priority / pending stage.
// Assumes imp_regs.svh holds the numeric register map.
package imp_pkg;

  // Register selected by a bus access
  typedef enum logic [2:0] {
    IMP_R_SRC,
    IMP_R_CLASS,
    IMP_R_MASK,
    IMP_R_ORDER,
    IMP_R_PEND,
    IMP_R_INDEX,
    IMP_R_NONE
  } imp_reg_sel_t;

  // One register write, valid for a single cycle
  typedef struct packed {
    logic         valid;
    imp_reg_sel_t sel;
    logic [31:0]  data;
  } imp_wr_t;

  // Source number of input idx of leaf group g; groups 0 and 5 use inputs 1..4
  function automatic logic [4:0] imp_src_index(input logic [2:0] g, input logic [2:0] idx);
    logic [4:0] base;
    base = 5'h00;
    case (g)
      3'h0:    base = 5'h00;
      3'h1:    base = 5'h04;
      3'h2:    base = 5'h0a;
      3'h3:    base = 5'h10;
      3'h4:    base = 5'h16;
      default: base = 5'h1c;
    endcase
    if (g == 3'h0 || g == 3'h5) begin
      imp_src_index = base + {2'b00, idx} - 5'h01;
    end else begin
      imp_src_index = base + {2'b00, idx};
    end
  endfunction : imp_src_index

endpackage : imp_pkg

// *** imp_regs.svh ***
// Register map, field positions and reset values of the interrupt
// mask / priority / pending stage. Definitions only; include by name.
`ifndef IMP_REGS_SVH
`define IMP_REGS_SVH

// Byte addresses of the registers on the register bus
`define IMP_SRC_ADDR    32'h4a000000
`define IMP_CLASS_ADDR  32'h4a000004
`define IMP_MASK_ADDR   32'h4a000008
`define IMP_ORDER_ADDR  32'h4a00000c
`define IMP_PEND_ADDR   32'h4a000010
`define IMP_INDEX_ADDR  32'h4a000014

// Reset values
`define IMP_SRC_RST     32'h00000000
`define IMP_CLASS_RST   32'h00000000
`define IMP_MASK_RST    32'hffffffff
`define IMP_ORDER_RST   32'h0000007f
`define IMP_PEND_RST    32'h00000000
`define IMP_INDEX_RST   5'h00

// Order control fields: rotate enables at [6:0], 2-bit order selects from bit 7
`define IMP_ROT_LSB     0
`define IMP_SEL_LSB     7
`define IMP_ORDER_USED  32'h001fffff

`endif

// *** irq_mask_priority_pending_tb.sv ***
// Self-checking bench for the interrupt mask / priority / pending stage.
// Assumes one AHB-Lite master (this bench) and the core model as far side.
`include "imp_regs.svh"

module irq_mask_priority_pending_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] src_req = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        normal_irq_req;
  logic        fast_interrupt_request;
  logic [7:0]  irq_entries;
  logic [7:0]  fast_entries;
  logic [31:0] rd;
  logic [31:0] seed;
  logic [31:0] msk;
  logic [31:0] elig;
  int          err_count = 0;
  int          compares = 0;
  int          n_irq = 0;

  always #12.5 hclk = ~hclk;

  imp_irq_stage DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_req(src_req),
    .normal_irq_req(normal_irq_req), .fast_interrupt_request(fast_interrupt_request));

  imp_core_model core (
    .hclk(hclk), .hresetn(hresetn), .normal_irq_req(normal_irq_req),
    .fast_interrupt_request(fast_interrupt_request), .irq_entries(irq_entries),
    .fast_entries(fast_entries));

  // Seeded shift register keeps random runs repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One bus phase: sample ready and data at the negedge, so the edge's updates never race
  task automatic phase(output logic [31:0] data);
    int   n;
    logic ok;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 20) begin
      @(negedge hclk);
      ok = (hreadyout === 1'b1);
      data = hrdata;
      n++;
      @(posedge hclk);
    end
    if (!ok) begin
      err_count++;
      report_and_stop();
    end
  endtask : phase

  // Single word transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    logic [31:0] x;
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    phase(x);
    htrans <= 2'h0;
    hwdata <= d;
    phase(r);
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask : rdc

  // One request burst, its checks, then the service clear sequence
  task automatic serve(input logic [31:0] req, input logic [31:0] pend);
    int idx;
    idx = 0;
    for (int k = 31; k >= 0; k--) if (pend[k]) idx = k;
    src_req <= req;
    @(posedge hclk);
    src_req <= 32'h0;
    repeat (2) @(posedge hclk);
    rdc(`IMP_SRC_ADDR, req);
    rdc(`IMP_PEND_ADDR, pend);
    rdc(`IMP_INDEX_ADDR, 32'(idx));
    @(negedge hclk);
    chk({31'h0, normal_irq_req}, {31'h0, pend != 32'h0});
    @(posedge hclk);
    if (pend != 32'h0) n_irq++;
    wr(`IMP_SRC_ADDR, 32'hffffffff);
    wr(`IMP_PEND_ADDR, 32'hffffffff);
    rdc(`IMP_PEND_ADDR, 32'h0);
  endtask : serve

  // Watchdog: a hang counts as a mismatch
  initial begin
    #1000000;
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and an unmapped word
    rdc(`IMP_MASK_ADDR, 32'hffffffff);
    rdc(`IMP_ORDER_ADDR, 32'h0000007f);
    rdc(`IMP_PEND_ADDR, 32'h0);
    rdc(`IMP_SRC_ADDR, 32'h0);
    rdc(`IMP_CLASS_ADDR, 32'h0);
    rdc(32'h4a00001c, 32'h0);
    // Fully masked source still flags but never loads
    serve(32'h00000400, 32'h0);
    wr(`IMP_ORDER_ADDR, 32'hffffffff);
    rdc(`IMP_ORDER_ADDR, `IMP_ORDER_USED);
    // Zero bits of a clear write leave pending and flag alone
    wr(`IMP_MASK_ADDR, 32'hfffffbff);
    rdc(`IMP_MASK_ADDR, 32'hfffffbff);
    src_req <= 32'h00000400;
    @(posedge hclk);
    src_req <= 32'h0;
    repeat (2) @(posedge hclk);
    wr(`IMP_PEND_ADDR, 32'hfffffbff);
    rdc(`IMP_PEND_ADDR, 32'h00000400);
    wr(`IMP_SRC_ADDR, 32'h0);
    rdc(`IMP_SRC_ADDR, 32'h00000400);
    wr(`IMP_SRC_ADDR, 32'h00000400);
    wr(`IMP_PEND_ADDR, 32'h00000400);
    rdc(`IMP_PEND_ADDR, 32'h0);
    n_irq++;
    // Every order code of a four-input and a six-input group, rotation off
    wr(`IMP_MASK_ADDR, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(`IMP_ORDER_ADDR, 32'(c) << 7);
      serve(32'h0000000f, 32'h1 << c);
    end
    for (int c = 0; c < 5; c++) begin
      wr(`IMP_ORDER_ADDR, 32'(c > 3 ? 3 : c) << 9);
      serve(c == 4 ? 32'h3f0 : 32'h3e0, c == 4 ? 32'h10 : 32'h20 << c);
    end
    // Fast class source bypasses the pending register
    wr(`IMP_CLASS_ADDR, 32'h00000008);
    rdc(`IMP_CLASS_ADDR, 32'h00000008);
    serve(32'h00000008, 32'h0);
    wr(`IMP_CLASS_ADDR, 32'h0);
    // Random masks and bursts; all codes 0 give lowest source first
    seed = 32'h00012b15;
    wr(`IMP_ORDER_ADDR, 32'h0);
    repeat (8) begin
      repeat (5) seed = lfsr(seed);
      msk = seed;
      wr(`IMP_MASK_ADDR, msk);
      repeat (5) seed = lfsr(seed);
      elig = seed & ~msk;
      serve(seed, elig & (~elig + 32'h1));
    end
    chk({24'h0, irq_entries}, 32'(n_irq));
    chk({24'h0, fast_entries}, 32'h1);
    report_and_stop();
  end
endmodule : irq_mask_priority_pending_tb
